// File: rtl/wda_alarm_regs.sv
// Weekly and daily alarm-setting registers with their two comparators.
`timescale 1ns/1ps


module wda_alarm_regs (
  // Clock and reset.
  input  wire logic                            clock,
  input  wire logic                            rst_n,
  // Register port from the serial link.
  input  wire logic [3:0]                      reg_addr,
  input  wire logic                            reg_wr,
  input  wire logic [wda_pkg::DATA_W-1:0]      reg_wdata,
  input  wire logic                            reg_rd,
  output logic      [wda_pkg::DATA_W-1:0]      reg_rdata,
  // Running time counters and mode.
  input  wire logic [wda_pkg::HOUR_W-1:0]      time_hour,
  input  wire logic [wda_pkg::MINUTE_W-1:0]    time_minute,
  input  wire logic [wda_pkg::WEEKDAY_W-1:0]   time_weekday,
  input  wire logic                            hour_24_mode,
  // Weekly alarm minute, held outside this block.
  input  wire logic [wda_pkg::MINUTE_W-1:0]    weekly_alarm_minute,
  // Oscillator-stop flag from the control logic.
  input  wire logic                            osc_stop_flag,
  // Alarm matches.
  output logic                                 weekly_match,
  output logic                                 daily_match
);

  // ----------------------------------------------------------------
  // Register storage.
  // ----------------------------------------------------------------

  // Only the defined bits are stored, so unused upper bits cannot hold ones.
  logic [wda_pkg::HOUR_W-1:0]    weekly_alarm_hour;          // Weekly alarm hour field.
  logic [wda_pkg::WEEKDAY_N-1:0] weekly_alarm_weekdays;      // Weekday enable bits.
  logic [wda_pkg::MINUTE_W-1:0]  daily_alarm_minute;         // Daily alarm minute field.
  logic [wda_pkg::HOUR_W-1:0]    daily_alarm_hour;           // Daily alarm hour field.
  logic [wda_pkg::HOUR_W-1:0]    next_weekly_alarm_hour;     // Next weekly hour.
  logic [wda_pkg::WEEKDAY_N-1:0] next_weekly_alarm_weekdays; // Next weekday enables.
  logic [wda_pkg::MINUTE_W-1:0]  next_daily_alarm_minute;    // Next daily minute.
  logic [wda_pkg::HOUR_W-1:0]    next_daily_alarm_hour;      // Next daily hour.
  logic                          osc_stop_seen;              // Delayed oscillator-stop flag.
  logic                          next_osc_stop_seen;         // Next delayed flag.
  logic                          osc_stop_rise;              // Flag has just become set.

  // Detects the moment the oscillator-stop flag becomes set.
  // The delayed copy resets low, which is the flag's idle level, so no false edge follows reset.
  // Only the edge clears the fields, so software can rewrite them while the flag still stands.
  assign osc_stop_rise      = osc_stop_flag && !osc_stop_seen;
  assign next_osc_stop_seen = osc_stop_flag;

  // Computes the next register contents from writes and the stop flag.
  always_comb
  begin
    next_weekly_alarm_hour     = weekly_alarm_hour;
    next_weekly_alarm_weekdays = weekly_alarm_weekdays;
    next_daily_alarm_minute    = daily_alarm_minute;
    next_daily_alarm_hour      = daily_alarm_hour;
    if (osc_stop_rise)
    begin
      // The contents are undefined after a stop; they are forced to a known value.
      next_weekly_alarm_hour     = wda_pkg::HOUR_RESET;
      next_weekly_alarm_weekdays = wda_pkg::WEEKDAYS_RESET;
      next_daily_alarm_minute    = wda_pkg::MINUTE_RESET;
      next_daily_alarm_hour      = wda_pkg::HOUR_RESET;
    end
    else if (reg_wr)
    begin
      // Upper bits of the write data are dropped on every register.
      unique case (reg_addr)
        wda_pkg::WEEKLY_ALARM_HOUR_OFS:
        begin
          next_weekly_alarm_hour = reg_wdata[wda_pkg::HOUR_W-1:0];
        end
        wda_pkg::WEEKLY_ALARM_WEEKDAYS_OFS:
        begin
          next_weekly_alarm_weekdays = reg_wdata[wda_pkg::WEEKDAY_N-1:0];
        end
        wda_pkg::DAILY_ALARM_MINUTE_OFS:
        begin
          next_daily_alarm_minute = reg_wdata[wda_pkg::MINUTE_W-1:0];
        end
        wda_pkg::DAILY_ALARM_HOUR_OFS:
        begin
          next_daily_alarm_hour = reg_wdata[wda_pkg::HOUR_W-1:0];
        end
        default:
        begin
          // Other addresses belong to other blocks.
          next_daily_alarm_hour = daily_alarm_hour;
        end
      endcase
    end
  end

  // Registers the alarm settings.
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      weekly_alarm_hour     <= wda_pkg::HOUR_RESET;
      weekly_alarm_weekdays <= wda_pkg::WEEKDAYS_RESET;
      daily_alarm_minute    <= wda_pkg::MINUTE_RESET;
      daily_alarm_hour      <= wda_pkg::HOUR_RESET;
      osc_stop_seen         <= 1'b0;
    end
    else
    begin
      weekly_alarm_hour     <= next_weekly_alarm_hour;
      weekly_alarm_weekdays <= next_weekly_alarm_weekdays;
      daily_alarm_minute    <= next_daily_alarm_minute;
      daily_alarm_hour      <= next_daily_alarm_hour;
      osc_stop_seen         <= next_osc_stop_seen;
    end
  end

  // ----------------------------------------------------------------
  // Read path.
  // ----------------------------------------------------------------

  logic [wda_pkg::DATA_W-1:0] next_reg_rdata;  // Next read data.

  // Selects read data; unused upper bits are padded with zeros.
  always_comb
  begin
    next_reg_rdata = reg_rdata;
    if (reg_rd)
    begin
      unique case (reg_addr)
        wda_pkg::WEEKLY_ALARM_HOUR_OFS:
        begin
          next_reg_rdata = {2'h0, weekly_alarm_hour};
        end
        wda_pkg::WEEKLY_ALARM_WEEKDAYS_OFS:
        begin
          next_reg_rdata = {1'h0, weekly_alarm_weekdays};
        end
        wda_pkg::DAILY_ALARM_MINUTE_OFS:
        begin
          next_reg_rdata = {1'h0, daily_alarm_minute};
        end
        wda_pkg::DAILY_ALARM_HOUR_OFS:
        begin
          next_reg_rdata = {2'h0, daily_alarm_hour};
        end
        default:
        begin
          // Addresses outside this block read as zero here.
          next_reg_rdata = wda_pkg::UNMAPPED_DATA;
        end
      endcase
    end
  end

  // Registers the read data; it holds until the next read.
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      reg_rdata <= wda_pkg::RDATA_RESET;
    end
    else
    begin
      reg_rdata <= next_reg_rdata;
    end
  end

  // ----------------------------------------------------------------
  // Alarm comparators.
  // ----------------------------------------------------------------

  // Both comparators map the stored hour and the running hour to one 0..23 count under the
  // same mode bit. In 12-hour mode the PM bit lifts the count into the afternoon half, and a
  // written 12 or 32 folds to hour zero of its half. In 24-hour mode the same bit weighs twenty.
  // An impossible stored hour folds to some count and may never match; software must avoid it.
  // The weekly minute is held outside this block and only compared here.
  logic weekday_enabled;  // Current weekday's enable bit is set.

  // Code 111 is no weekday and never matches; all-zero enables never match.
  always_comb
  begin
    weekday_enabled = 1'b0;
    if (time_weekday != 3'h7)
    begin
      weekday_enabled = weekly_alarm_weekdays[time_weekday];
    end
  end

  // Weekly alarm: hour, minute and weekday.
  wda_match u_weekly (
    .clock        (clock),
    .rst_n        (rst_n),
    .enable       (weekday_enabled),
    .alarm_hour   (weekly_alarm_hour),
    .alarm_minute (weekly_alarm_minute),
    .time_hour    (time_hour),
    .time_minute  (time_minute),
    .hour_24_mode (hour_24_mode),
    .match        (weekly_match)
  );

  // Daily alarm: hour and minute only.
  wda_match u_daily (
    .clock        (clock),
    .rst_n        (rst_n),
    .enable       (1'b1),
    .alarm_hour   (daily_alarm_hour),
    .alarm_minute (daily_alarm_minute),
    .time_hour    (time_hour),
    .time_minute  (time_minute),
    .hour_24_mode (hour_24_mode),
    .match        (daily_match)
  );

  // ----------------------------------------------------------------
  // Assertions and covers.
  // ----------------------------------------------------------------

  // All checks here run on the one clock and are muted while reset is held.
  // Storage checks look one cycle after the strobe, when the register has taken the value.
  // Read checks look one cycle after the read strobe, when the read data stands.
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  // A write to the weekly hour lands in storage with bits 7:6 dropped.
  weekly_hour_wr_a: assert property (reg_wr && !osc_stop_rise && reg_addr == 4'h9
    |=> weekly_alarm_hour == $past(reg_wdata[5:0]))
    else $error("weekly hour write lost");

  // Weekly hour bits 7:6 read zero.
  weekly_hour_top_a: assert property (reg_rd && reg_addr == 4'h9 |=> reg_rdata[7:6] == 2'h0)
    else $error("weekly hour upper bits not zero");

  // Weekday register bit 7 reads zero.
  weekday_top_a: assert property (reg_rd && reg_addr == 4'hA |=> reg_rdata[7] == 1'b0)
    else $error("weekday bit 7 not zero");

  // Daily minute bit 7 reads zero and the field follows the store.
  daily_min_rd_a: assert property (reg_rd && reg_addr == 4'hB
    |=> reg_rdata == {1'b0, $past(daily_alarm_minute)})
    else $error("daily minute read wrong");

  // Daily hour bits 7:6 read zero.
  daily_hour_rd_a: assert property (reg_rd && reg_addr == 4'hC |=> reg_rdata[7:6] == 2'h0)
    else $error("daily hour upper bits not zero");

  // No enabled weekday means no weekly match.
  no_weekday_a: assert property (weekly_alarm_weekdays == 7'h00 |=> !weekly_match)
    else $error("weekly match with no weekday enabled");

  // A weekly match needs the weekday's enable bit.
  weekday_gate_a: assert property (weekly_match |-> $past(weekday_enabled))
    else $error("weekly match on disabled weekday");

  // A daily match needs equal minutes one cycle earlier.
  daily_cause_a: assert property (daily_match |-> $past(time_minute == daily_alarm_minute))
    else $error("daily match without minute equality");

  // An oscillator stop leaves known contents with zero upper bits.
  osc_stop_clear_a: assert property ($rose(osc_stop_flag) |=> daily_alarm_hour == 6'h00
    && weekly_alarm_weekdays == 7'h00)
    else $error("alarm fields not cleared after oscillator stop");

  // A stop that rises with a write wins over the write.
  stop_over_wr_a: assert property (osc_stop_rise && reg_wr |=> weekly_alarm_hour == 6'h00
    && daily_alarm_minute == 7'h00 && daily_alarm_hour == 6'h00)
    else $error("write survived an oscillator stop");

  // A weekly match needs equal minutes one cycle earlier.
  weekly_cause_a: assert property (weekly_match |-> $past(time_minute == weekly_alarm_minute))
    else $error("weekly match without minute equality");

  // In 12-hour mode noon written as 32 never matches midnight 12.
  noon_not_mid_a: assert property (!hour_24_mode && daily_alarm_hour == 6'h32 && time_hour == 6'h12
    |=> !daily_match)
    else $error("noon alarm matched at midnight");

  // In 24-hour mode bit 5 weighs twenty, so an alarm at 23 matches 23.
  tens_twenty_a: assert property (hour_24_mode && daily_alarm_hour == 6'h23 && time_hour == 6'h23
    && time_minute == daily_alarm_minute |=> daily_match)
    else $error("24-hour alarm at 23 missed");

  // Covers of the main scenarios.
  weekly_hit_c: cover property (reg_wr && reg_addr == 4'hA ##[1:20] weekly_match);
  daily_hit_c: cover property (reg_wr && reg_addr == 4'hC ##[1:20] daily_match);
  noon_12h_c: cover property (!hour_24_mode && daily_alarm_hour == 6'h32 && daily_match);
  osc_stop_c: cover property ($rose(osc_stop_flag));
  stop_over_wr_c: cover property (osc_stop_rise && reg_wr);

endmodule : wda_alarm_regs

// File: rtl/wda_pkg.sv
// Package of register offsets, field layouts and helpers for the alarm-setting registers.
package wda_pkg;

  // ----------------------------------------------------------------
  // Register offsets on the four-bit register address.
  // ----------------------------------------------------------------
  localparam logic [3:0] WEEKLY_ALARM_HOUR_OFS     = 4'h9;  // Weekly alarm hour.
  localparam logic [3:0] WEEKLY_ALARM_WEEKDAYS_OFS = 4'hA;  // Weekly alarm weekday enables.
  localparam logic [3:0] DAILY_ALARM_MINUTE_OFS    = 4'hB;  // Daily alarm minute.
  localparam logic [3:0] DAILY_ALARM_HOUR_OFS      = 4'hC;  // Daily alarm hour.

  // ----------------------------------------------------------------
  // Field widths and positions.
  // ----------------------------------------------------------------
  localparam int HOUR_W     = 6;  // Hour field occupies bits 5 to 0.
  localparam int MINUTE_W   = 7;  // Minute field occupies bits 6 to 0.
  localparam int WEEKDAY_N  = 7;  // Number of weekday enable bits.
  localparam int WEEKDAY_W  = 3;  // Width of the weekday counter code.
  localparam int DATA_W     = 8;  // Register data width.
  localparam int HOUR_PM_BIT = 5; // Bit 5: PM flag in 12-hour mode, tens-20 bit in 24-hour mode.
  localparam int HOUR_TEN_BIT = 4; // Bit 4: tens-10 bit of the hour.

  // ----------------------------------------------------------------
  // Values after reset and after an oscillator stop, and read data of unmapped addresses.
  // ----------------------------------------------------------------
  localparam logic [HOUR_W-1:0]    HOUR_RESET     = 6'h00;
  localparam logic [MINUTE_W-1:0]  MINUTE_RESET   = 7'h00;
  localparam logic [WEEKDAY_N-1:0] WEEKDAYS_RESET = 7'h00;
  localparam logic [DATA_W-1:0]    RDATA_RESET    = 8'h00;
  localparam logic [DATA_W-1:0]    UNMAPPED_DATA  = 8'h00;

  // ----------------------------------------------------------------
  // Hour decoding shared by both alarm comparators.
  // ----------------------------------------------------------------

  // Turns a BCD hour field into a 0..23 hour count for either mode.
  function automatic logic [4:0] hour_to_24(input logic [HOUR_W-1:0] h, input logic mode_24);
    logic [4:0] units;
    logic [4:0] count;
    units = {1'b0, h[3:0]};
    count = 5'h00;
    if (mode_24)
    begin
      // Bit 5 weighs 20 and bit 4 weighs 10.
      count = units + (h[HOUR_PM_BIT] ? 5'h14 : 5'h00) + (h[HOUR_TEN_BIT] ? 5'h0A : 5'h00);
    end
    else
    begin
      // Hour 12 stands for hour zero; bit 5 adds the afternoon half.
      count = units + (h[HOUR_TEN_BIT] ? 5'h0A : 5'h00);
      if (count == 5'h0C)
      begin
        count = 5'h00;
      end
      count = count + (h[HOUR_PM_BIT] ? 5'h0C : 5'h00);
    end
    return count;
  endfunction : hour_to_24

endpackage : wda_pkg

// File: rtl/wda_match.sv
// One alarm comparator: hour and minute against the running time.
`timescale 1ns/1ps

module wda_match (
  // Clock and reset.
  input  wire logic                           clock,
  input  wire logic                           rst_n,
  // Qualifier from the caller, such as the weekday gate.
  input  wire logic                           enable,
  // Stored alarm time.
  input  wire logic [wda_pkg::HOUR_W-1:0]     alarm_hour,
  input  wire logic [wda_pkg::MINUTE_W-1:0]   alarm_minute,
  // Running time and hour mode.
  input  wire logic [wda_pkg::HOUR_W-1:0]     time_hour,
  input  wire logic [wda_pkg::MINUTE_W-1:0]   time_minute,
  input  wire logic                           hour_24_mode,
  // Registered match.
  output logic                                match
);

  logic next_match;  // Next value of the match flop.

  // Compares both hour fields after mapping to a common 0..23 count.
  always_comb
  begin
    next_match = enable
      && (wda_pkg::hour_to_24(alarm_hour, hour_24_mode)
          == wda_pkg::hour_to_24(time_hour, hour_24_mode))
      && (alarm_minute == time_minute);
  end

  // Registers the match.
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      match <= 1'b0;
    end
    else
    begin
      match <= next_match;
    end
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  // Midnight written as 12 matches a counter at 12 in 12-hour mode.
  midnight_match_a: assert property (enable && !hour_24_mode && alarm_hour == 6'h12 && time_hour == 6'h12
    && alarm_minute == time_minute |=> match)
    else $error("12-hour midnight did not match");

  // In 12-hour mode the PM bit separates morning from afternoon.
  pm_split_a: assert property (!hour_24_mode && (alarm_hour[5] != time_hour[5]) |=> !match)
    else $error("match across AM and PM");

endmodule : wda_match

// File: dv/wda_host.sv
// Host model that reaches the alarm registers one byte at a time.
`timescale 1ns/1ps

module wda_host (
  // Clock.
  input  wire logic                       clock,
  // Register port towards the block.
  output logic [3:0]                      reg_addr,
  output logic                            reg_wr,
  output logic [wda_pkg::DATA_W-1:0]      reg_wdata,
  output logic                            reg_rd,
  input  wire logic [wda_pkg::DATA_W-1:0] reg_rdata
);
  // Idle bus at time zero; data shows junk while no write is taken.
  initial
  begin
    reg_addr  = 4'h0;
    reg_wr    = 1'b0;
    reg_wdata = 8'h5A;
    reg_rd    = 1'b0;
  end

  // One write strobe; address and data then flip so stale values never match.
  task automatic write_reg(input logic [3:0] a, input logic [7:0] d);
    @(posedge clock);
    #1;
    reg_addr  = a;
    reg_wdata = d;
    reg_wr    = 1'b1;
    @(posedge clock);
    #1;
    reg_wr    = 1'b0;
    reg_wdata = ~d;
    reg_addr  = ~a;
  endtask : write_reg

  // One read strobe; the byte is taken the cycle after the strobe.
  task automatic read_reg(input logic [3:0] a, output logic [7:0] d);
    @(posedge clock);
    #1;
    reg_addr = a;
    reg_rd   = 1'b1;
    @(posedge clock);
    #1;
    reg_rd   = 1'b0;
    reg_addr = ~a;
    d        = reg_rdata;
  endtask : read_reg
endmodule : wda_host

// File: dv/testbench.sv
// Self-checking bench for the weekly and daily alarm registers.
`timescale 1ns/1ps

module testbench;
  // ----------------------------------------------------------------
  // Signals.
  // ----------------------------------------------------------------
  logic       clock;
  logic       rst_n;
  logic [3:0] reg_addr;
  logic       reg_wr;
  logic [7:0] reg_wdata;
  logic       reg_rd;
  logic [7:0] reg_rdata;
  logic [5:0] time_hour;
  logic [6:0] time_minute;
  logic [2:0] time_weekday;
  logic       hour_24_mode;
  logic [6:0] weekly_alarm_minute;
  logic       osc_stop_flag;
  logic       weekly_match;
  logic       daily_match;
  int         err_total;
  int         checked;
  logic [7:0] rd_val;

  // Clock of 8 ns period.
  initial clock = 1'b0;
  always #4 clock = ~clock;

  wda_alarm_regs dut_u (.clock(clock), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .time_hour(time_hour),
    .time_minute(time_minute), .time_weekday(time_weekday), .hour_24_mode(hour_24_mode),
    .weekly_alarm_minute(weekly_alarm_minute), .osc_stop_flag(osc_stop_flag),
    .weekly_match(weekly_match), .daily_match(daily_match));

  wda_host host_u (.clock(clock), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata));

  // ----------------------------------------------------------------
  // Helpers.
  // ----------------------------------------------------------------
  task automatic finish_test();
    $display("Comparisons %0d, mismatches %0d.", checked, err_total);
    if (err_total == 0 && checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : finish_test

  // Compares one value and counts the outcome.
  task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
    checked++;
    if (got !== exp)
    begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  // Reads one register and compares it.
  task automatic rd_chk(input logic [3:0] a, input logic [7:0] exp);
    host_u.read_reg(a, rd_val);
    check($sformatf("reg %h", a), exp, rd_val);
  endtask : rd_chk

  // Drives the running time, lets the registered matches settle, compares both.
  task automatic at_time(input logic [5:0] h, input logic [6:0] m, input logic [2:0] w,
                         input logic exp_w, input logic exp_d);
    @(posedge clock);
    #1;
    time_hour    = h;
    time_minute  = m;
    time_weekday = w;
    repeat (2) @(posedge clock);
    #1;
    check("weekly_match", {7'h00, exp_w}, {7'h00, weekly_match});
    check("daily_match", {7'h00, exp_d}, {7'h00, daily_match});
  endtask : at_time

  // Cuts a hang short.
  initial
  begin
    #(8 * 20000);
    err_total++;
    finish_test();
  end

  // ----------------------------------------------------------------
  // Test sequence.
  // ----------------------------------------------------------------
  initial
  begin
    err_total           = 0;
    checked             = 0;
    rst_n               = 1'b0;
    time_hour           = 6'h01;
    time_minute         = 7'h01;
    time_weekday        = 3'h0;
    hour_24_mode        = 1'b1;
    weekly_alarm_minute = 7'h15;
    osc_stop_flag       = 1'b0;
    repeat (20) @(posedge clock);
    #1;
    rst_n = 1'b1;
    // Cleared storage after reset.
    for (int a = 9; a <= 12; a++)
      rd_chk(a[3:0], 8'h00);
    // Upper bits drop on write and read as zero.
    host_u.write_reg(4'h9, 8'hFF);
    rd_chk(4'h9, 8'h3F);
    host_u.write_reg(4'hA, 8'hFF);
    rd_chk(4'hA, 8'h7F);
    host_u.write_reg(4'hB, 8'hFF);
    rd_chk(4'hB, 8'h7F);
    host_u.write_reg(4'hC, 8'hFF);
    rd_chk(4'hC, 8'h3F);
    // Unmapped places neither store nor alias.
    host_u.write_reg(4'hD, 8'hA5);
    rd_chk(4'hD, 8'h00);
    rd_chk(4'h8, 8'h00);
    rd_chk(4'h9, 8'h3F);
    // Daily alarm in 24-hour mode with bit 5 as tens-20.
    host_u.write_reg(4'hB, 8'h30);
    host_u.write_reg(4'hC, 8'h23);
    host_u.write_reg(4'hA, 8'h00);
    at_time(6'h23, 7'h30, 3'h0, 1'b0, 1'b1);
    at_time(6'h23, 7'h31, 3'h0, 1'b0, 1'b0);
    at_time(6'h03, 7'h30, 3'h0, 1'b0, 1'b0);
    // Twelve-hour mode: 12 is midnight, 32 is noon.
    hour_24_mode = 1'b0;
    host_u.write_reg(4'hB, 8'h00);
    host_u.write_reg(4'hC, 8'h12);
    at_time(6'h12, 7'h00, 3'h0, 1'b0, 1'b1);
    at_time(6'h32, 7'h00, 3'h0, 1'b0, 1'b0);
    host_u.write_reg(4'hC, 8'h32);
    at_time(6'h32, 7'h00, 3'h0, 1'b0, 1'b1);
    at_time(6'h12, 7'h00, 3'h0, 1'b0, 1'b0);
    // Weekly alarm: one enable bit per weekday code, code 7 never matches.
    hour_24_mode = 1'b1;
    host_u.write_reg(4'h9, 8'h07);
    for (int k = 0; k < 7; k++)
    begin
      host_u.write_reg(4'hA, 8'h01 << k);
      for (int w = 0; w < 8; w++)
        at_time(6'h07, 7'h15, w[2:0], w == k, 1'b0);
    end
    // No weekday enabled means no weekly match on any day.
    host_u.write_reg(4'hA, 8'h00);
    for (int w = 0; w < 7; w++)
      at_time(6'h07, 7'h15, w[2:0], 1'b0, 1'b0);
    // Minute must agree as well.
    host_u.write_reg(4'hA, 8'h7F);
    at_time(6'h07, 7'h15, 3'h2, 1'b1, 1'b0);
    weekly_alarm_minute = 7'h16;
    at_time(6'h07, 7'h15, 3'h2, 1'b0, 1'b0);
    // Weekly alarm in 12-hour mode: noon written as 32 is not midnight.
    hour_24_mode        = 1'b0;
    weekly_alarm_minute = 7'h15;
    host_u.write_reg(4'h9, 8'h32);
    at_time(6'h32, 7'h15, 3'h4, 1'b1, 1'b0);
    at_time(6'h12, 7'h15, 3'h4, 1'b0, 1'b0);
    // Oscillator stop spoils the alarm fields, even a write taken in the same cycle.
    host_u.write_reg(4'hB, 8'h45);
    fork
      host_u.write_reg(4'hC, 8'h11);
      begin
        @(posedge clock);
        #1;
        osc_stop_flag = 1'b1;
      end
    join
    repeat (2) @(posedge clock);
    #1;
    osc_stop_flag = 1'b0;
    for (int a = 9; a <= 12; a++)
      rd_chk(a[3:0], 8'h00);
    finish_test();
  end
endmodule : testbench
